// File: ptsc_pkg.sv
package ptsc_pkg;
  // ==========================================================
  // Widths and resets
  localparam int CNT_W = 10;
  localparam logic [9:0] CNT_RST = 10'h000;
  localparam logic [9:0] PERIOD_RST = 10'h3ff;
  // ==========================================================
  // Mode encodings
  localparam logic [1:0] START_CMD_CAP = 2'h0;
  localparam logic [1:0] START_CMD_TRG = 2'h1;
  localparam logic [1:0] START_TRG = 2'h2;
  localparam logic [1:0] STOP_INIT = 2'h0;
  localparam logic [1:0] STOP_HOLD = 2'h1;
  localparam logic [1:0] STOP_END = 2'h2;

  typedef struct packed {
    logic [1:0] start_mode_select;
    logic [1:0] stop_mode_select;
    logic trigger_polarity_select;
    logic trigger_accept_mode;
    logic out_a_initial_level;
    logic out_b_initial_level;
    logic out_a_enable;
    logic out_b_enable;
  } ptsc_cfg_t;

  typedef struct packed {
    logic rd_rise_low;
    logic rd_rise_high;
    logic rd_fall_low;
    logic rd_fall_high;
  } ptsc_cap_rd_t;

  typedef enum logic [1:0] {
    PTSC_IDLE,
    PTSC_WAIT_TRIG,
    PTSC_RUN
  } ptsc_state_t;
endpackage

// File: ptsc_trig_sync.sv
`timescale 1ns/100ps
// ==========================================================
// Trigger input synchroniser and edge detect
module ptsc_trig_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic trigger_input,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= trigger_input;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;
endmodule // ptsc_trig_sync

// File: ptsc_core.sv
`timescale 1ns/100ps
module ptsc_core
  import ptsc_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire ptsc_cfg_t cfg,
  input wire logic count_run_bit,
  input wire logic [WIDTH-1:0] period,
  input wire logic [WIDTH-1:0] dead_time,
  input wire logic [WIDTH-1:0] pulse_width,
  input wire logic trigger_input,
  input wire ptsc_cap_rd_t cap_rd,
  output logic [WIDTH-1:0] rise_capture_reg,
  output logic [WIDTH-1:0] fall_capture_reg,
  output logic cap_protected,
  output logic counter_busy_flag,
  output logic [WIDTH-1:0] count,
  output logic pulse_out_a,
  output logic pulse_out_b
);
  if (WIDTH < 2 || WIDTH > 16) begin : g_chk
    $error("ptsc_core: WIDTH out of range");
  end

  // ==========================================================
  // Trigger sampling
  logic trg_level;
  logic trg_rise;
  logic trg_fall;

  ptsc_trig_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .trigger_input(trigger_input),
    .level(trg_level),
    .rise(trg_rise),
    .fall(trg_fall)
  );

  // ==========================================================
  // Control decode
  logic run_prev_ff;
  logic [1:0] stm_prev_ff;
  logic run_set;
  logic run_clr;
  logic stm_to_end;
  logic trig_mode;
  logic cap_mode;
  logic at_stop_level;
  logic start_edge;
  logic period_end;
  logic act_a;
  logic act_b;
  logic outs_active;
  logic accept_ok;
  logic stop_accept;
  logic start_accept;
  logic stop_pend_ff;
  logic oneshot_done_ff;
  ptsc_state_t state_ff;
  ptsc_state_t nxt_state;
  logic [WIDTH-1:0] cnt_ff;
  logic raw_a;
  logic raw_b;
  logic hold_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      run_prev_ff <= 1'b0;
      stm_prev_ff <= STOP_INIT;
    end else begin
      run_prev_ff <= count_run_bit;
      stm_prev_ff <= cfg.stop_mode_select;
    end
  end

  assign run_set = count_run_bit & ~run_prev_ff;
  assign run_clr = ~count_run_bit & run_prev_ff;
  assign stm_to_end = count_run_bit & run_prev_ff
                    & (cfg.stop_mode_select == STOP_END) & (stm_prev_ff != STOP_END);
  assign trig_mode = (cfg.start_mode_select != START_CMD_CAP);
  assign cap_mode = (cfg.start_mode_select == START_CMD_CAP);
  // Falling edge starts when polarity 0, rising when 1
  assign at_stop_level = trig_mode & (trg_level ^ cfg.trigger_polarity_select);
  assign start_edge = trig_mode & (cfg.trigger_polarity_select ? trg_rise : trg_fall);
  assign period_end = (state_ff == PTSC_RUN) && (cnt_ff >= period - 1'b1);

  // Active means an enabled output differs from its initial level
  assign act_a = cfg.out_a_enable & (pulse_out_a ^ cfg.out_a_initial_level);
  assign act_b = cfg.out_b_enable & (pulse_out_b ^ cfg.out_b_initial_level);
  assign outs_active = act_a | act_b;
  assign accept_ok = ~cfg.trigger_accept_mode | ~outs_active;

  // Stop level is acted on as a level, so a deferred one lands when outputs go idle
  assign stop_accept = count_run_bit & at_stop_level & accept_ok
                     & (state_ff == PTSC_RUN);
  assign start_accept = count_run_bit & start_edge & accept_ok & ~at_stop_level
                      & (state_ff == PTSC_WAIT_TRIG) & ~oneshot_done_ff;

  // ==========================================================
  // Run state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PTSC_IDLE: begin
        if (run_set) begin
          // Trigger start mode never counts on a write
          if (cfg.start_mode_select == START_TRG || at_stop_level) begin
            nxt_state = PTSC_WAIT_TRIG;
          end else begin
            nxt_state = PTSC_RUN;
          end
        end
      end
      PTSC_WAIT_TRIG: begin
        if (!count_run_bit) begin
          nxt_state = PTSC_IDLE;
        end else if (start_accept) begin
          nxt_state = PTSC_RUN;
        end
      end
      PTSC_RUN: begin
        if (run_clr && cfg.stop_mode_select != STOP_END) begin
          nxt_state = PTSC_IDLE;
        end else if (stop_accept) begin
          nxt_state = PTSC_WAIT_TRIG;
        end else if (period_end && (stop_pend_ff || run_clr)) begin
          nxt_state = PTSC_IDLE;
        end else if (period_end && cfg.stop_mode_select == STOP_END) begin
          nxt_state = trig_mode ? PTSC_WAIT_TRIG : PTSC_IDLE;
        end
      end
      default: nxt_state = PTSC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= PTSC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Deferred stop request under stop mode 10
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stop_pend_ff <= 1'b0;
    end else if (nxt_state != PTSC_RUN) begin
      stop_pend_ff <= 1'b0;
    end else if (run_clr && cfg.stop_mode_select == STOP_END) begin
      stop_pend_ff <= 1'b1;
    end
  end

  // One-time stop blocks further start triggers and captures
  always_ff @(posedge clk) begin
    if (!nrst) begin
      oneshot_done_ff <= 1'b0;
    end else if (run_set || !count_run_bit) begin
      oneshot_done_ff <= 1'b0;
    end else if (state_ff == PTSC_RUN && stop_accept && cfg.stop_mode_select == STOP_END) begin
      oneshot_done_ff <= 1'b1;
    end
  end

  assign counter_busy_flag = (state_ff == PTSC_RUN);

  // ==========================================================
  // Counter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= WIDTH'(CNT_RST);
    end else if (nxt_state != PTSC_RUN) begin
      if (!(state_ff == PTSC_RUN && run_clr && cfg.stop_mode_select == STOP_HOLD)) begin
        cnt_ff <= '0;
      end
    end else if (state_ff != PTSC_RUN || period_end || stm_to_end
                 || (run_set && cap_mode)) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign count = cnt_ff;

  // ==========================================================
  // Pulse outputs: positive logic shapes, then initial level flips
  assign raw_a = (cnt_ff >= dead_time) && (cnt_ff < pulse_width);
  assign raw_b = (cnt_ff >= pulse_width + dead_time);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold_ff <= 1'b0;
    end else if (state_ff == PTSC_RUN && run_clr && cfg.stop_mode_select == STOP_HOLD) begin
      hold_ff <= 1'b1;
    end else if (nxt_state == PTSC_RUN || run_set) begin
      hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pulse_out_a <= 1'b0;
      pulse_out_b <= 1'b0;
    end else if (hold_ff && nxt_state != PTSC_RUN && !run_set) begin
      pulse_out_a <= pulse_out_a;
      pulse_out_b <= pulse_out_b;
    end else if (nxt_state != PTSC_RUN || state_ff != PTSC_RUN) begin
      pulse_out_a <= cfg.out_a_initial_level;
      pulse_out_b <= cfg.out_b_initial_level;
    end else begin
      pulse_out_a <= raw_a ^ cfg.out_a_initial_level;
      pulse_out_b <= raw_b ^ cfg.out_b_initial_level;
    end
  end

  // ==========================================================
  // Capture buffer and protected capture registers
  logic [WIDTH-1:0] buf_rise_ff;
  logic [WIDTH-1:0] buf_fall_ff;
  logic cap_en;
  assign cap_en = cap_mode & count_run_bit & (state_ff == PTSC_RUN)
                & ~oneshot_done_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      buf_rise_ff <= '0;
      buf_fall_ff <= '0;
    end else if (cap_en) begin
      if (trg_rise) begin
        buf_rise_ff <= cnt_ff;
      end
      if (trg_fall) begin
        buf_fall_ff <= cnt_ff;
      end
    end
  end

  // High-byte read of B wins so a full set read always unlocks
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cap_protected <= 1'b0;
    end else if (cap_rd.rd_fall_high) begin
      cap_protected <= 1'b0;
    end else if (cap_rd.rd_rise_low || cap_rd.rd_rise_high || cap_rd.rd_fall_low) begin
      cap_protected <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rise_capture_reg <= '0;
      fall_capture_reg <= '0;
    end else if (cap_en && period_end && !cap_protected) begin
      rise_capture_reg <= trg_rise ? cnt_ff : buf_rise_ff;
      fall_capture_reg <= trg_fall ? cnt_ff : buf_fall_ff;
    end
  end
endmodule // ptsc_core

// File: ptsc_trig_src.sv
`timescale 1ns/100ps
// ==========================================================
// Trigger source: pin follows the request lag+1 falling edges after it changes
module ptsc_trig_src (
  input wire logic clk,
  input wire logic want,
  input wire logic [3:0] lag,
  output logic trigger_input
);
  logic [3:0] wait_ff;
  initial trigger_input = 1'b0;
  initial wait_ff = 4'h0;
  // Slow source when lag is nonzero; both edges see the same delay
  always @(negedge clk) begin
    if (want == trigger_input) begin
      wait_ff <= 4'h0;
    end else if (wait_ff >= lag) begin
      trigger_input <= want;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule // ptsc_trig_src

// File: ptsc_core_checker.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker
module ptsc_chk
  import ptsc_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire ptsc_cfg_t cfg,
  input wire logic count_run_bit,
  input wire logic trigger_input,
  input wire ptsc_cap_rd_t cap_rd,
  input wire logic [WIDTH-1:0] rise_capture_reg,
  input wire logic [WIDTH-1:0] fall_capture_reg,
  input wire logic cap_protected,
  input wire logic counter_busy_flag,
  input wire logic [WIDTH-1:0] count,
  input wire logic pulse_out_a,
  input wire logic pulse_out_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic tm;
  logic at_stop;
  assign tm = count_run_bit && cfg.start_mode_select == START_TRG && !cfg.trigger_accept_mode;
  assign at_stop = trigger_input != cfg.trigger_polarity_select;
  sequence stop_seen;
    (tm && at_stop)[*4];
  endsequence
  sequence start_seen;
    (tm && !at_stop && cfg.stop_mode_select != STOP_END)[*7];
  endsequence
  cmd_start_a: assert property ($rose(count_run_bit) && cfg.start_mode_select == START_CMD_CAP
    |-> ##[1:3] (counter_busy_flag && count == '0)) else $error("command start missed");
  arm_only_a: assert property (at_stop[*4] ##0 ($rose(count_run_bit) &&
    cfg.start_mode_select == START_TRG) |=> !counter_busy_flag[*3]) else $error("run write started");
  stop_level_a: assert property (stop_seen |-> ##[0:3] (!counter_busy_flag && count == '0))
    else $error("stop level did not clear");
  trig_start_a: assert property (stop_seen ##1 start_seen |-> counter_busy_flag)
    else $error("start edge missed");
  idle_off_a: assert property ((!count_run_bit && cfg.stop_mode_select != STOP_END)[*4]
    |-> !counter_busy_flag) else $error("busy while stopped");
  run_fall_a: assert property ($fell(count_run_bit) && cfg.stop_mode_select == STOP_INIT
    |-> ##[1:3] (!counter_busy_flag && count == '0 && pulse_out_a == cfg.out_a_initial_level
    && pulse_out_b == cfg.out_b_initial_level)) else $error("stop did not init");
  rd_lock_a: assert property ((cap_rd.rd_rise_low || cap_rd.rd_rise_high ||
    cap_rd.rd_fall_low) && !cap_rd.rd_fall_high |=> cap_protected) else $error("no lock");
  rd_unlock_a: assert property (cap_rd.rd_fall_high |=> !cap_protected)
    else $error("no unlock");
  cap_hold_a: assert property (cap_protected && !cap_rd.rd_fall_high |=>
    $stable(rise_capture_reg) && $stable(fall_capture_reg)) else $error("locked capture moved");
endmodule // ptsc_chk

bind ptsc_core ptsc_chk #(.WIDTH(WIDTH)) u_chk (.clk(clk), .nrst(nrst), .cfg(cfg),
  .count_run_bit(count_run_bit), .trigger_input(trigger_input), .cap_rd(cap_rd),
  .rise_capture_reg(rise_capture_reg), .fall_capture_reg(fall_capture_reg),
  .cap_protected(cap_protected), .counter_busy_flag(counter_busy_flag), .count(count),
  .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b));

// File: ptsc_core_tb.sv
`timescale 1ns/100ps
// ==========================================================
// Testbench
module ptsc_core_tb;
  import ptsc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  ptsc_cfg_t cfg;
  logic count_run_bit = 1'b0;
  logic want = 1'b0;
  logic trigger_input;
  ptsc_cap_rd_t cap_rd = '0;
  logic [9:0] rise_capture_reg, fall_capture_reg, count, keep;
  logic cap_protected, counter_busy_flag, pulse_out_a, pulse_out_b;
  int fail_count = 0;
  int checked = 0;
  always #4 clk = ~clk;
  ptsc_trig_src u_src (.clk(clk), .want(want), .lag(4'h2), .trigger_input(trigger_input));
  ptsc_core u_dut (.clk(clk), .nrst(nrst), .cfg(cfg), .count_run_bit(count_run_bit),
    .period(10'h028), .dead_time(10'h002), .pulse_width(10'h008),
    .trigger_input(trigger_input), .cap_rd(cap_rd), .rise_capture_reg(rise_capture_reg),
    .fall_capture_reg(fall_capture_reg), .cap_protected(cap_protected),
    .counter_busy_flag(counter_busy_flag), .count(count), .pulse_out_a(pulse_out_a),
    .pulse_out_b(pulse_out_b));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One byte read, one cycle long
  task automatic rd(input int b);
    cap_rd = ptsc_cap_rd_t'(4'h1 << b);
    cyc(1);
    cap_rd = '0;
  endtask
  task automatic wait_busy(input logic v, input int n);
    for (int i = 0; i < n && counter_busy_flag !== v; i++) cyc(1);
    check({9'h0, counter_busy_flag}, {9'h0, v});
  endtask
  task automatic pulse_at(input logic [9:0] c, input int w);
    while (count !== c) cyc(1);
    want <= 1'b1;
    cyc(w);
    want <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(6000);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    cfg = '{START_CMD_CAP, STOP_INIT, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    cyc(16);
    nrst = 1'b1;
    cyc(1);
    count_run_bit = 1'b1;
    wait_busy(1'b1, 4);
    // Dummy read set clears any stale lock
    for (int b = 3; b >= 0; b--) rd(b);
    check({9'h0, cap_protected}, 10'h000);
    pulse_at(10'h002, 10);
    cyc(45);
    check(fall_capture_reg - rise_capture_reg, 10'h00a);
    keep = rise_capture_reg;
    cyc(40);
    check(rise_capture_reg, keep);
    rd(3);
    check({9'h0, cap_protected}, 10'h001);
    pulse_at(10'h014, 5);
    cyc(45);
    check(rise_capture_reg, keep);
    rd(0);
    check({9'h0, cap_protected}, 10'h000);
    cyc(45);
    check(fall_capture_reg - rise_capture_reg, 10'h005);
    count_run_bit = 1'b0;
    cyc(3);
    check({counter_busy_flag, count}, 11'h000);
    check({8'h0, pulse_out_a, pulse_out_b}, 10'h002);
    cfg.stop_mode_select = STOP_END;
    count_run_bit = 1'b1;
    wait_busy(1'b1, 4);
    wait_busy(1'b0, 50);
    count_run_bit = 1'b0;
    cfg.stop_mode_select = STOP_INIT;
    cfg.start_mode_select = START_TRG;
    for (int p = 0; p < 2; p++) begin
      cfg.trigger_polarity_select = p[0];
      want <= ~p[0];
      cyc(8);
      count_run_bit = 1'b1;
      cyc(6);
      check({9'h0, counter_busy_flag}, 10'h000);
      want <= p[0];
      wait_busy(1'b1, 10);
      cyc(4);
      want <= ~p[0];
      cyc(8);
      check({counter_busy_flag, count}, 11'h000);
      count_run_bit = 1'b0;
      cyc(4);
      want <= p[0];
      cyc(10);
      check({9'h0, counter_busy_flag}, 10'h000);
    end
    tally_and_finish();
  end
endmodule // ptsc_core_tb
